// ===== src/uit_ctrl.sv
/*
 * Guard-time counter, receive time-out counter with flag and interrupt,
 * and infrared front end (debounce, inversion, loopback, direction).
 * Assumes the baud tick, word events and serial bits come from logic on
 * i_sys_clk; only the line input is asynchronous.
 */
// Register access over Avalon-MM is done here, with one wait cycle.
`timescale 1ns/1ns

// How it works
// - Guard counter restarts on each sent word
// - Next word waits until counter equals guard
// - Time-out counter runs only when enabled
// - Time-out counts ticks, restarts on received data
// - Counter match raises interrupt if enabled
// - Received word or drained queue clears counter
// - Debounce counts down, prescaler divides clock
// - Pulses shorter than prescale period are dropped
// - Receive invert flips incoming line
// - Transmit invert flips outgoing line
// - Loopback feeds transmit back into receive
// - Direction picks infrared receiver or transmitter
// - Low-power bit selects infrared low power
// - Enable bit switches infrared front end in
// - Time-out flag set by hardware, write-1-clear
module uit_ctrl (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Port core events
    input  wire logic        i_baud_tick,
    input  wire logic        i_tx_word_sent,
    input  wire logic        i_rx_word_pushed,
    input  wire logic        i_rx_fifo_read,
    input  wire logic        i_rx_fifo_empty,
    output logic             o_tx_allow,
    output logic             o_rx_timeout_irq,
    // Serial bits to and from the port core
    input  wire logic        i_tx_data,
    output logic             o_rx_data,
    // Line and transceiver
    input  wire logic        i_line_rx,
    output logic             o_line_tx,
    output logic             o_ir_rx_enable,
    output logic             o_ir_tx_enable,
    output logic             o_ir_low_power
);
    // All state of the block
    typedef struct packed {
        logic [31:0] rdata;
        logic        wait_n;    // Low marks the answering cycle
        logic [15:0] timing;
        logic [15:0] infra;
        logic        toie;
        logic [7:0]  g_cnt;
        logic        g_busy;
        logic        tx_allow;
        logic [6:0]  t_cnt;
        logic        t_armed;
        logic        flag;
        logic        irq;
        logic [2:0]  sync;      // Line synchroniser, [0] first
        logic        filt;      // Value once stages two and three agree
        logic        deb;       // Debounced receive level
        logic [7:0]  db_cnt;
        logic        rx_out;
        logic        tx_out;
        logic        ir_rx_en;  // Transceiver receive enable
        logic        ir_tx_en;  // Transceiver transmit enable
    } uit_state_s;

    uit_state_s r;       // Registered state
    uit_state_s next_r;  // Next state

    // Field views
    logic [7:0] tg;
    logic       to_en;
    logic [6:0] to_cmp;
    logic [7:0] psc;
    logic       acc;
    logic       wr_stat;

    assign tg     = r.timing[uit_pkg::TG_LSB +: 8];
    assign to_en  = r.timing[uit_pkg::TO_EN_BIT];
    assign to_cmp = r.timing[uit_pkg::TO_LSB +: 7];
    assign psc    = r.infra[uit_pkg::PSC_LSB +: 8];
    assign acc    = (i_avs_read || i_avs_write) && !r.wait_n;
    assign wr_stat = acc && i_avs_write && i_avs_address == uit_pkg::OFF_STATUS;

    // Register read mux, unmapped addresses read zero
    function automatic logic [31:0] rd_mux(input logic [7:0] a, input uit_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            uit_pkg::OFF_TIMING:   v[15:0] = s.timing;
            uit_pkg::OFF_INFRARED: v[15:0] = s.infra & 16'hff3f;
            uit_pkg::OFF_STATUS: begin
                v[uit_pkg::FLAG_BIT]  = s.flag;
                v[uit_pkg::BUSY_BIT]  = s.g_busy;
                v[uit_pkg::ARMED_BIT] = s.t_armed;
            end
            uit_pkg::OFF_IRQ_EN:   v[uit_pkg::TOIE_BIT] = s.toie;
            default:               v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Next-state logic
    always_comb begin
        logic rx_src;
        logic tx_src;
        rx_src = 1'b1;
        tx_src = 1'b1;
        next_r = r;

        // Bus: one wait cycle, answer in the second. The extra cycle
        // lets readdata leave a flop instead of a wide mux on the pins
        next_r.wait_n = !((i_avs_read || i_avs_write) && r.wait_n);
        if ((i_avs_read || i_avs_write) && r.wait_n) begin
            next_r.rdata = rd_mux(i_avs_address, r);
        end
        if (acc && i_avs_write) begin
            unique case (i_avs_address)
                uit_pkg::OFF_TIMING:   next_r.timing = i_avs_writedata[15:0];
                uit_pkg::OFF_INFRARED: next_r.infra  = i_avs_writedata[15:0] & 16'hff3f;
                uit_pkg::OFF_IRQ_EN:   next_r.toie   = i_avs_writedata[uit_pkg::TOIE_BIT];
                default: ;
            endcase
        end

        // Guard window: closes when count reaches guard value
        if (i_tx_word_sent) begin
            next_r.g_cnt  = uit_pkg::RST_GUARD_CNT;
            next_r.g_busy = 1'b1;
        end else if (r.g_busy) begin
            if (r.g_cnt == tg) begin
                next_r.g_busy = 1'b0;
            end else if (i_baud_tick) begin
                next_r.g_cnt = r.g_cnt + 8'h01;
            end
        end
        next_r.tx_allow = !next_r.g_busy;

        // Receive time-out counter; stops at the match so that one idle
        // spell gives a single event, not a stream of them
        if (!to_en) begin
            next_r.t_cnt   = uit_pkg::RST_TO_CNT;
            next_r.t_armed = 1'b0;
        end else if (i_rx_word_pushed) begin
            next_r.t_cnt   = uit_pkg::RST_TO_CNT;
            next_r.t_armed = 1'b1;
        end else if (i_rx_fifo_read && i_rx_fifo_empty) begin
            next_r.t_cnt   = uit_pkg::RST_TO_CNT;
            next_r.t_armed = 1'b0;
        end else if (r.t_armed) begin
            if (r.t_cnt == to_cmp) begin
                next_r.t_armed = 1'b0; // One event per idle spell
            end else if (i_baud_tick) begin
                next_r.t_cnt = r.t_cnt + 7'h01;
            end
        end

        // Flag: a set in the clearing cycle wins
        if (wr_stat && i_avs_writedata[uit_pkg::FLAG_BIT]) begin
            next_r.flag = 1'b0;
        end
        if (to_en && r.t_armed && r.t_cnt == to_cmp && !i_rx_word_pushed
            && !(i_rx_fifo_read && i_rx_fifo_empty)) begin
            next_r.flag = 1'b1;
        end
        next_r.irq = next_r.flag && next_r.toie;

        // Line synchroniser; change counts when stages agree
        next_r.sync = {r.sync[1:0], i_line_rx};
        if (r.sync[1] == r.sync[2]) begin
            next_r.filt = r.sync[2] ^ r.infra[uit_pkg::RECEIVE_INVERT_BIT];
        end

        // Debounce: level must hold a full prescale period
        // A zero prescaler wraps to 256 cycles, so it never lets glitches through
        if (r.filt == r.deb) begin
            next_r.db_cnt = 8'(psc - 8'h01);
        end else if (r.db_cnt == uit_pkg::RST_DB_CNT) begin
            next_r.deb    = r.filt;
            next_r.db_cnt = 8'(psc - 8'h01);
        end else begin
            next_r.db_cnt = r.db_cnt - 8'h01;
        end

        // Receive source: loopback, infrared or plain line
        if (r.infra[uit_pkg::LB_BIT]) begin
            rx_src = i_tx_data;
        end else if (r.infra[uit_pkg::IREN_BIT]) begin
            rx_src = r.infra[uit_pkg::DIR_BIT] ? 1'b1 : r.deb;
        end else begin
            rx_src = r.filt;
        end
        next_r.rx_out = rx_src;

        // Transmit: idle high while infrared receives
        if (r.infra[uit_pkg::IREN_BIT] && !r.infra[uit_pkg::DIR_BIT]) begin
            tx_src = 1'b1;
        end else begin
            tx_src = i_tx_data;
        end
        next_r.tx_out = tx_src ^ r.infra[uit_pkg::TRANSMIT_INVERT_BIT];

        // Transceiver enables taken from the next control value, so they
        // move on the same edge as the register write and leave a flop
        next_r.ir_rx_en = next_r.infra[uit_pkg::IREN_BIT]
                          & ~next_r.infra[uit_pkg::DIR_BIT];
        next_r.ir_tx_en = next_r.infra[uit_pkg::IREN_BIT]
                          & next_r.infra[uit_pkg::DIR_BIT];
    end

    // State register, synchronous reset
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            r          <= '0;
            r.wait_n   <= 1'b1;
            r.timing   <= uit_pkg::RST_TIMING[15:0];
            r.infra    <= uit_pkg::RST_INFRARED[15:0];
            r.toie     <= uit_pkg::RST_IRQ_EN[uit_pkg::TOIE_BIT];
            r.tx_allow <= 1'b1;
            r.sync     <= 3'h7;
            r.filt     <= 1'b1;
            r.deb      <= 1'b1;
            r.rx_out   <= 1'b1;
            r.tx_out   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign o_avs_readdata    = r.rdata;
    assign o_avs_waitrequest = r.wait_n;
    assign o_tx_allow        = r.tx_allow;
    assign o_rx_timeout_irq  = r.irq;
    assign o_rx_data         = r.rx_out;
    assign o_line_tx         = r.tx_out;
    // Direction and power straight from control flops
    assign o_ir_rx_enable    = r.ir_rx_en;
    assign o_ir_tx_enable    = r.ir_tx_en;
    assign o_ir_low_power    = r.infra[uit_pkg::LP_BIT];

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_word_sent;
        i_tx_word_sent;
    endsequence
    sequence s_timeout_hit;
        to_en && r.t_armed && r.t_cnt == to_cmp && !i_rx_word_pushed
        && !(i_rx_fifo_read && i_rx_fifo_empty);
    endsequence

    chk_guard_restart: assert property (s_word_sent |=> r.g_cnt == 8'h00 && r.g_busy)
        else $error("guard counter not restarted");
    chk_guard_hold: assert property (s_word_sent |=> !o_tx_allow)
        else $error("word not held off");
    chk_guard_step: assert property (r.g_busy && i_baud_tick && r.g_cnt != tg
        && !i_tx_word_sent |=> r.g_cnt == $past(r.g_cnt) + 8'h01)
        else $error("guard counter step wrong");
    chk_guard_still: assert property (r.g_busy && !i_baud_tick && !i_tx_word_sent
        |=> $stable(r.g_cnt))
        else $error("guard counter moved without tick");
    chk_guard_release: assert property (r.g_busy && r.g_cnt == tg && !i_tx_word_sent
        |=> o_tx_allow)
        else $error("guard window not closed at match");
    chk_rxto_off: assert property (!to_en |=> r.t_cnt == 7'h00 && !r.t_armed)
        else $error("time-out ran while disabled");
    chk_rxto_restart: assert property (to_en && i_rx_word_pushed |=> r.t_cnt == 7'h00)
        else $error("time-out not restarted");
    chk_rxto_drain: assert property (to_en && i_rx_fifo_read && i_rx_fifo_empty
        && !i_rx_word_pushed |=> !r.t_armed && r.t_cnt == 7'h00)
        else $error("drained queue kept counter");
    chk_rxto_step: assert property (to_en && r.t_armed && i_baud_tick
        && r.t_cnt != to_cmp && !i_rx_word_pushed
        && !(i_rx_fifo_read && i_rx_fifo_empty) |=> r.t_cnt == $past(r.t_cnt) + 7'h01)
        else $error("time-out counter step wrong");
    // Flag and interrupt rise on the same edge, the interrupt gated by its enable
    chk_flag_set: assert property (s_timeout_hit |=> r.flag && o_rx_timeout_irq == r.toie)
        else $error("time-out flag or interrupt missing");
    chk_flag_hold: assert property (r.flag
        && !(wr_stat && i_avs_writedata[uit_pkg::FLAG_BIT]) |=> r.flag)
        else $error("time-out flag lost without a clear");
    chk_irq_gate: assert property (o_rx_timeout_irq == (r.flag && r.toie))
        else $error("interrupt not gated by enable");
    chk_debounce: assert property ($changed(r.deb) |-> $past(r.db_cnt) == 8'h00)
        else $error("debounce changed early");
    chk_loopback: assert property ($past(r.infra[uit_pkg::LB_BIT])
        |-> o_rx_data == $past(i_tx_data))
        else $error("loopback path broken");
    // The first edge out of reset still shows the idle-high reset level
    chk_tx_invert: assert property (!$past(i_sys_rst)
        && !$past(r.infra[uit_pkg::IREN_BIT])
        |-> o_line_tx == ($past(i_tx_data) ^ $past(r.infra[uit_pkg::TRANSMIT_INVERT_BIT])))
        else $error("transmit inversion wrong");
    chk_ir_tx_idle: assert property (!$past(i_sys_rst)
        && $past(r.infra[uit_pkg::IREN_BIT]) && !$past(r.infra[uit_pkg::DIR_BIT])
        |-> o_line_tx == !$past(r.infra[uit_pkg::TRANSMIT_INVERT_BIT]))
        else $error("line not idle while receiving");
endmodule

// ===== src/uit_pkg.sv
/*
 * Constants for the guard-time, receive time-out and infrared control block.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package uit_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_TIMING    = 8'h14; // timing_parameters
    localparam logic [7:0] OFF_INFRARED  = 8'h18; // infrared_control
    localparam logic [7:0] OFF_STATUS    = 8'h40; // status, flag is write-1-clear
    localparam logic [7:0] OFF_IRQ_EN    = 8'h44; // interrupt_enable_register
    // Reset values
    localparam logic [31:0] RST_TIMING   = 32'h0000_0000;
    localparam logic [31:0] RST_INFRARED = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_EN   = 32'h0000_0000;
    // timing_parameters fields
    localparam int TG_LSB    = 8;  // guard_time_value [15:8]
    localparam int TO_EN_BIT = 7;  // receive_timeout_enable
    localparam int TO_LSB    = 0;  // receive_timeout_compare [6:0]
    // infrared_control fields
    localparam int PSC_LSB   = 8;  // debounce_prescaler [15:8]
    localparam int RECEIVE_INVERT_BIT = 5;  // receive_invert
    localparam int TRANSMIT_INVERT_BIT = 4;  // transmit_invert
    localparam int LB_BIT    = 3;  // loopback_select
    localparam int DIR_BIT   = 2;  // infrared_direction
    localparam int LP_BIT    = 1;  // infrared_low_power
    localparam int IREN_BIT  = 0;  // infrared_mode_enable
    // Status and enable fields
    localparam int FLAG_BIT  = 0;  // receive_timeout_flag
    localparam int BUSY_BIT  = 1;  // guard window still open
    localparam int ARMED_BIT = 2;  // time-out counter running
    localparam int TOIE_BIT  = 0;  // receive_timeout_irq_enable
    // Counter reset values
    localparam logic [7:0] RST_GUARD_CNT = 8'h00;
    localparam logic [6:0] RST_TO_CNT    = 7'h00;
    localparam logic [7:0] RST_DB_CNT    = 8'h00;
endpackage

// ===== bench/uit_ir_peer.sv
/*
 * Infrared transceiver stand-in for the line input of uit_ctrl.
 * Assumes pulse requests arrive on the block's own clock.
 */
`timescale 1ns/1ns
module uit_ir_peer (
    // Clock
    input  wire logic       i_clk,
    // Pulse request
    input  wire logic       i_go,
    input  wire logic [7:0] i_len,
    // Line towards the block
    output logic            o_line
);
    logic [7:0] left = 8'h00; // Low clocks still to send

    // Released receiver output idles high, so a pulse is a low spell
    always @(posedge i_clk) begin
        if (i_go) begin
            left <= i_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign o_line = (left == 8'h00);
endmodule

// ===== bench/uart_guard_timeout_irda_ctrl_test.sv
/*
 * Self-checking bench for uit_ctrl: bus tasks, event pulses, random
 * infrared settings. Assumes the peer model holds the line idle high.
 */
`timescale 1ns/1ns
module uart_guard_timeout_irda_ctrl_test;
    logic        clk = 1'b0;      // Bench clock
    logic        rst = 1'b1;      // Sync reset
    logic [7:0]  adr = 8'h00;     // Bus request
    logic        rd  = 1'b0;
    logic        wr  = 1'b0;
    logic [31:0] wd  = 32'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic [4:0]  evt = 5'h00;     // tick, sent, push, pop, empty
    logic        txd = 1'b0;      // Serial bit from core
    logic        allow, irq, rxd, line, ltx, ren, ten, lp;
    logic        go  = 1'b0;      // Peer pulse request
    logic [7:0]  len = 8'h00;
    logic [31:0] seed = 32'd94952;
    logic [31:0] q, cfg;
    logic [1:0]  e;
    logic        b, saw;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    uit_ctrl u_dut (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_baud_tick(evt[0]), .i_tx_word_sent(evt[1]),
        .i_rx_word_pushed(evt[2]), .i_rx_fifo_read(evt[3]), .i_rx_fifo_empty(evt[4]),
        .o_tx_allow(allow), .o_rx_timeout_irq(irq), .i_tx_data(txd), .o_rx_data(rxd),
        .i_line_rx(line), .o_line_tx(ltx), .o_ir_rx_enable(ren), .o_ir_tx_enable(ten),
        .o_ir_low_power(lp)
    );
    uit_ir_peer u_peer (.i_clk(clk), .i_go(go), .i_len(len), .o_line(line));

    // 4 ns period
    always #2 clk = ~clk;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Hold the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic ev(input logic [4:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 5'h00;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Low pulse on the line, then watch the receive bit for a low
    task automatic glitch(input logic [7:0] n);
        @(posedge clk);
        go  <= 1'b1;
        len <= n;
        @(posedge clk);
        go  <= 1'b0;
        saw = 1'b0;
        repeat (40) begin
            @(posedge clk);
            if (rxd === 1'b0) saw = 1'b1;
        end
    endtask

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Line level for a transmit bit: idle-high receiver, then invert
    function automatic logic tx_exp(input logic [31:0] c, input logic d);
        return ((c[0] && !c[2]) ? 1'b1 : d) ^ c[4];
    endfunction

    // Receive bit, if known, with the line held high by the peer
    function automatic logic [1:0] rx_exp(input logic [31:0] c, input logic d);
        if (c[3]) return {1'b1, d};
        if (!c[0]) return {1'b1, ~c[5]};
        return {c[2], 1'b1};
    endfunction

    initial begin
        idle(3);
        rst <= 1'b0;
        // Reset values and an unmapped place
        bus(0, uit_pkg::OFF_TIMING, 0);
        chk(q, uit_pkg::RST_TIMING);
        bus(0, uit_pkg::OFF_INFRARED, 0);
        chk(q, uit_pkg::RST_INFRARED);
        bus(0, 8'h30, 0);
        chk(q, 32'h0);
        // Round trip, reserved bits read zero, prescaler never zero
        repeat (4) begin
            cfg = xs();
            bus(1, uit_pkg::OFF_TIMING, cfg);
            bus(0, uit_pkg::OFF_TIMING, 0);
            chk(q, cfg & 32'hffff);
            bus(1, uit_pkg::OFF_INFRARED, cfg | 32'h100);
            bus(0, uit_pkg::OFF_INFRARED, 0);
            chk(q, (cfg | 32'h100) & 32'hff3f);
        end
        // Guard of 3 ticks, with idle cycles between ticks
        bus(1, uit_pkg::OFF_TIMING, 32'h300);
        ev(5'h02);
        ev(5'h01);
        ev(5'h01);
        idle(5);
        chk(allow, 0);
        ev(5'h01);
        idle(1);
        chk(allow, 0);
        idle(1);
        chk(allow, 1);
        // Time-out, compare 2, masked first
        bus(1, uit_pkg::OFF_TIMING, 32'h82);
        ev(5'h04);
        ev(5'h01);
        ev(5'h01);
        idle(4);
        chk(irq, 0);
        bus(1, uit_pkg::OFF_IRQ_EN, 32'h1);
        idle(2);
        chk(irq, 1);
        bus(0, uit_pkg::OFF_STATUS, 0);
        chk(q[0], 1);
        bus(1, uit_pkg::OFF_STATUS, 32'h1);
        idle(2);
        chk(irq, 0);
        // New word restarts the count
        ev(5'h04);
        ev(5'h01);
        ev(5'h04);
        ev(5'h01);
        idle(4);
        chk(irq, 0);
        ev(5'h01);
        idle(3);
        chk(irq, 1);
        bus(1, uit_pkg::OFF_STATUS, 32'h1);
        // Drained queue clears, then a disabled counter
        ev(5'h04);
        ev(5'h01);
        ev(5'h18);
        repeat (3) ev(5'h01);
        idle(4);
        chk(irq, 0);
        bus(1, uit_pkg::OFF_TIMING, 32'h02);
        ev(5'h04);
        repeat (4) ev(5'h01);
        idle(4);
        chk(irq, 0);
        // Random infrared settings against transmit and receive paths
        repeat (30) begin
            cfg = (xs() & 32'h3f) | 32'h100;
            bus(1, uit_pkg::OFF_INFRARED, cfg);
            repeat (4) begin
                b = 1'(xs());
                @(posedge clk);
                txd <= b;
                @(posedge clk);
                #1;
                chk(ltx, tx_exp(cfg, b));
                e = rx_exp(cfg, b);
                if (e[1]) chk(rxd, e[0]);
                if (cfg[0]) chk({ren, ten, lp}, {~cfg[2], cfg[2], cfg[1]});
                else chk({ren, ten, lp}, {2'b00, cfg[1]});
            end
        end
        // Debounce with prescaler 4: short pulse dropped, long one kept
        bus(1, uit_pkg::OFF_INFRARED, 32'h401);
        idle(20);
        glitch(8'h02);
        chk(saw, 0);
        glitch(8'h14);
        chk(saw, 1);
        end_of_test();
    end
endmodule
